/* File: inc/mel_pkg.sv */
// mel_pkg: field layout, encodings and carriers for the memory error log
package mel_pkg;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MISC_COL_LO = 9;
    localparam int MISC_ROW_LO = 19;
    localparam int MISC_BANK_LO = 40;
    localparam int MISC_DEV_LO = 46;
    localparam int MISC_SRANK_LO = 52;
    localparam int MISC_RANK_LO = 56;
    localparam int MISC_MODE_LO = 59;
    localparam int MISC_TRANS_BIT = 63;
    localparam int MISC_LOW_W = 9;
    localparam int ST_CODE_W = 16;
    localparam int ST_MSCOD_LO = 16;
    localparam int ST_RD_BIT = 16;
    localparam int ST_PWR_BIT = 18;
    localparam int ST_FWR_BIT = 19;
    localparam int ST_BUF_BIT = 20;
    localparam int ST_TMO_BIT = 21;
    localparam int ST_PAR_BIT = 22;
    localparam int ST_FATAL_BIT = 23;
    localparam int ST_TYPE_LO = 24;
    localparam int ST_MISC_LO = 26;
    localparam int ST_OTHER_LO = 32;
    localparam int ST_VALID_BIT = 63;

    // reserved bits that must read zero: column 18,17,9; bank 45; st 17 and 62:38
    localparam logic [63:0] MISC_RSVD_MASK = 64'h0000_2000_0006_0200;
    localparam logic [63:0] ST_RSVD_MASK = 64'h7fff_ffc0_0002_0000;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_SDC_MEM = 4'h0;
    localparam logic [3:0] MODE_SDC_APPLIED = 4'h1;
    localparam logic [3:0] MODE_ADC_MEM = 4'h4;
    localparam logic [3:0] MODE_ADC_APPLIED = 4'h5;
    localparam logic [3:0] MODE_PMEM_READ = 4'h8;
    localparam logic [7:0] CODE_CMP_MARK = 8'h80;
    localparam logic [7:0] CODE_CMP_MASK = 8'hff;
    localparam logic [63:0] REG_RESET = 64'h0;
    // bank number of the single-agent variant status register
    localparam logic [7:0] SINGLE_AGENT_BANK = 8'h0c;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] column;
        logic [20:0] row;
        logic [5:0] bank;
        logic [5:0] device;
        logic [3:0] stack_rank;
        logic [2:0] rank;
        logic [3:0] mode;
        logic transient;
        logic correctable;
    } mel_addr_t;

    typedef struct packed {
        logic [2:0] txn_type;
        logic [3:0] channel;
        logic read_data_error_flag;
        logic partial_write_error_flag;
        logic full_write_error_flag;
        logic crossing_buffer_error_flag;
        logic agent_timeout_flag;
        logic tracker_parity_flag;
        logic fatal_bucket_one_flag;
        logic [1:0] memory_type_error_field;
        logic [5:0] misc_error_field;
        logic [5:0] other_info;
    } mel_event_t;

endpackage

/* File: logic/mel_misc_fmt.sv */
// mel_misc_fmt: packs an address capture into the detail log word
`timescale 1ns/1ps
module mel_misc_fmt (
    input wire mel_pkg::mel_addr_t addr_i, // captured failing address
    input wire logic [8:0] low_i, // bits 8:0 passed through
    output logic [63:0] word_o // formatted detail word
);
    logic [3:0] mode_q;
    logic [5:0] dev_q;
    logic [63:0] raw;

    always_comb
    begin
        mode_q = addr_i.mode;
        unique case (addr_i.mode)
            mel_pkg::MODE_SDC_MEM, mel_pkg::MODE_SDC_APPLIED,
            mel_pkg::MODE_ADC_MEM, mel_pkg::MODE_ADC_APPLIED,
            mel_pkg::MODE_PMEM_READ: mode_q = addr_i.mode;
            default: mode_q = addr_i.mode; // reserved codes logged raw
        endcase
        // device id only carries meaning on correctable, non-transient
        dev_q = (addr_i.correctable && !addr_i.transient)
            ? addr_i.device : 6'h00;
        raw = {addr_i.transient,
               mode_q,
               addr_i.rank, addr_i.stack_rank,
               dev_q,
               addr_i.bank, addr_i.row, addr_i.column,
               low_i};
        word_o = raw & ~mel_pkg::MISC_RSVD_MASK;
    end
endmodule

/* File: logic/mel_status_fmt.sv */
// mel_status_fmt: packs an agent event into the status word
`timescale 1ns/1ps
module mel_status_fmt (
    input wire mel_pkg::mel_event_t ev_i, // agent event fields
    output logic [63:0] word_o // formatted status, valid clear
);
    logic [63:0] raw;

    always_comb
    begin
        raw = mel_pkg::REG_RESET;
        raw[mel_pkg::ST_CODE_W-1:0] = {8'h00, mel_pkg::CODE_CMP_MARK
            | {1'b0, ev_i.txn_type, ev_i.channel}};
        raw[mel_pkg::ST_RD_BIT] = ev_i.read_data_error_flag;
        raw[mel_pkg::ST_PWR_BIT] = ev_i.partial_write_error_flag;
        raw[mel_pkg::ST_FWR_BIT] = ev_i.full_write_error_flag;
        raw[mel_pkg::ST_BUF_BIT] = ev_i.crossing_buffer_error_flag;
        raw[mel_pkg::ST_TMO_BIT] = ev_i.agent_timeout_flag;
        raw[mel_pkg::ST_PAR_BIT] = ev_i.tracker_parity_flag;
        raw[mel_pkg::ST_FATAL_BIT] = ev_i.fatal_bucket_one_flag;
        raw[mel_pkg::ST_TYPE_LO +: 2] = ev_i.memory_type_error_field;
        raw[mel_pkg::ST_MISC_LO +: 6] = ev_i.misc_error_field;
        raw[mel_pkg::ST_OTHER_LO +: 6] = ev_i.other_info;
        word_o = raw & ~mel_pkg::ST_RSVD_MASK;
    end
endmodule

/* File: logic/mel_error_log.sv */
// mel_error_log: status and detail log registers for one memory error bank
`timescale 1ns/1ps
module mel_error_log #(
    parameter logic [7:0] BANK_ID = mel_pkg::SINGLE_AGENT_BANK
) (
    input wire logic clock_i, // 10 MHz clock
    input wire logic reset_i, // synchronous, active high
    input wire logic ev_valid_i, // one-cycle pulse: agent event
    input wire mel_pkg::mel_event_t ev_i, // agent event fields
    input wire logic addr_valid_i, // one-cycle pulse: address capture
    input wire mel_pkg::mel_addr_t addr_i, // failing address fields
    input wire logic [8:0] misc_low_i, // detail bits 8:0
    input wire logic clear_i, // one-cycle pulse: software clear
    output logic [63:0] status_o, // mesh_memory_error_status
    output logic [63:0] detail_o, // memory_error_detail_log
    output logic valid_o, // entry_valid_flag
    output logic [7:0] bank_o // reporting bank number
);
    // ------------------------------------------------------------
    // formatting
    // ------------------------------------------------------------
    logic [63:0] st_word;
    logic [63:0] misc_word;
    logic [63:0] status_r;
    logic [63:0] detail_r;
    logic valid_r;
    logic dvalid_r;
    logic [7:0] bank_r;

    mel_status_fmt u_st (
        .ev_i(ev_i),
        .word_o(st_word)
    );

    mel_misc_fmt u_misc (
        .addr_i(addr_i),
        .low_i(misc_low_i),
        .word_o(misc_word)
    );

    // ------------------------------------------------------------
    // status register: first event wins, held until clear
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            status_r <= mel_pkg::REG_RESET;
            valid_r <= 1'b0;
        end
        else if (ev_valid_i && (!valid_r || clear_i))
        begin
            // set wins over a clear in the same cycle
            status_r <= st_word;
            status_r[mel_pkg::ST_VALID_BIT] <= 1'b1;
            valid_r <= 1'b1;
        end
        else if (clear_i)
        begin
            status_r <= mel_pkg::REG_RESET;
            valid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // detail register: captured once per entry
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            detail_r <= mel_pkg::REG_RESET;
            dvalid_r <= 1'b0;
        end
        else if (addr_valid_i && (!dvalid_r || clear_i))
        begin
            detail_r <= misc_word;
            dvalid_r <= 1'b1;
        end
        else if (clear_i)
        begin
            detail_r <= mel_pkg::REG_RESET;
            dvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            bank_r <= 8'h00;
        else
            bank_r <= BANK_ID;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        status_o = status_r;
        detail_o = detail_r;
        valid_o = valid_r;
        bank_o = bank_r;
    end
endmodule

/* File: verif/mel_error_log_monitor.sv */
// mel_error_log_monitor: port-level checks of the memory error log
`timescale 1ns/1ps
module mel_error_log_monitor #(
    parameter logic [7:0] BANK_ID = mel_pkg::SINGLE_AGENT_BANK
) (
    input wire logic clock_i, // clock
    input wire logic reset_i, // reset
    input wire logic ev_valid_i, // event pulse
    input wire mel_pkg::mel_event_t ev_i, // event fields
    input wire logic addr_valid_i, // capture pulse
    input wire mel_pkg::mel_addr_t addr_i, // address fields
    input wire logic [8:0] misc_low_i, // low detail bits
    input wire logic clear_i, // clear pulse
    input wire logic [63:0] status_o, // status word
    input wire logic [63:0] detail_o, // detail word
    input wire logic valid_o, // valid flag
    input wire logic [7:0] bank_o // bank number
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    mel_pkg::mel_event_t ev_q;
    mel_pkg::mel_addr_t a_q;
    logic [8:0] ml_q;
    wire logic ev_take = ev_valid_i && (!valid_o || clear_i);
    wire logic a_take = addr_valid_i && clear_i;
    always_ff @(posedge clock_i) ev_q <= ev_i;
    always_ff @(posedge clock_i) a_q <= addr_i;
    always_ff @(posedge clock_i) ml_q <= misc_low_i;
    property p_code;
        ev_take |=> status_o[15:0] == {9'h001, ev_q[27:21]};
    endproperty
    property p_flag;
        ev_take |=> status_o[23:16] == {ev_q[14], ev_q[15], ev_q[16],
            ev_q[17], ev_q[18], ev_q[19], 1'b0, ev_q[20]};
    endproperty
    property p_info;
        ev_take |=> status_o[37:24] == {ev_q[5:0], ev_q[11:6], ev_q[13:12]};
    endproperty
    property p_valid;
        ev_take |=> valid_o && status_o[63];
    endproperty
    property p_hold;
        valid_o && !clear_i |=> $stable(status_o) && valid_o;
    endproperty
    property p_clear;
        clear_i && !ev_valid_i |=> !valid_o && status_o == 64'h0;
    endproperty
    property p_rsvd;
        ((status_o & mel_pkg::ST_RSVD_MASK)
            | (detail_o & mel_pkg::MISC_RSVD_MASK)) == 64'h0;
    endproperty
    property p_mode;
        a_take |=> detail_o[63:52] == {a_q.transient, a_q.mode, a_q.rank,
            a_q.stack_rank};
    endproperty
    property p_dev;
        a_take |=> detail_o[51:46] ==
            ((a_q.correctable && !a_q.transient) ? a_q.device : 6'h00);
    endproperty
    property p_addr;
        a_take |=> detail_o[45:0] == {1'b0, a_q.bank[4:0], a_q.row,
            a_q.column & 10'h0fe, ml_q};
    endproperty
    property p_bank;
        !$past(reset_i) |-> bank_o == BANK_ID;
    endproperty
    a_code: assert property (p_code) else $error("code wrong");
    a_flag:
    assert property (p_flag) else $error("flag bits wrong");
    a_info: assert property (p_info) else $error("info wrong");
    a_valid: assert property (p_valid) else $error("valid unset");
    a_hold: assert property (p_hold) else $error("status moved");
    a_clear: assert property (p_clear) else $error("not cleared");
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    a_mode:
    assert property (p_mode) else $error("mode or rank wrong");
    a_dev: assert property (p_dev) else $error("device wrong");
    a_addr: assert property (p_addr) else $error("address wrong");
    a_bank: assert property (p_bank) else $error("bank wrong");
    c_event: cover property (ev_take);
    c_refused: cover property (ev_valid_i && valid_o && !clear_i);
    c_capture: cover property (a_take);
endmodule
bind mel_error_log mel_error_log_monitor #(.BANK_ID(BANK_ID)) i_mon (
    .clock_i(clock_i), .reset_i(reset_i), .ev_valid_i(ev_valid_i),
    .ev_i(ev_i), .addr_valid_i(addr_valid_i), .addr_i(addr_i),
    .misc_low_i(misc_low_i), .clear_i(clear_i), .status_o(status_o),
    .detail_o(detail_o), .valid_o(valid_o), .bank_o(bank_o));

/* File: verif/mel_error_log_tb.sv */
// mel_error_log_tb: directed checks of the memory error log registers
`timescale 1ns/1ps
module mel_error_log_tb;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic ev_valid_i = 1'b0;
    logic addr_valid_i = 1'b0;
    logic clear_i = 1'b0;
    logic [8:0] misc_low_i = 9'h000;
    mel_pkg::mel_event_t ev_i = '0;
    mel_pkg::mel_addr_t addr_i = '0;
    logic [63:0] status_o;
    logic [63:0] detail_o;
    logic [63:0] exp;
    logic valid_o;
    logic [7:0] bank_o;
    int num_errors = 0;
    int cmp_count = 0;
    logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8};
    always #50 clock_i = ~clock_i;
    mel_error_log i_dut (.clock_i(clock_i), .reset_i(reset_i),
        .ev_valid_i(ev_valid_i), .ev_i(ev_i), .addr_valid_i(addr_valid_i),
        .addr_i(addr_i), .misc_low_i(misc_low_i), .clear_i(clear_i),
        .status_o(status_o), .detail_o(detail_o), .valid_o(valid_o),
        .bank_o(bank_o));
    task automatic chk(input string nm, input logic [63:0] got,
        input logic [63:0] want);
        cmp_count++;
        if (got !== want)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, want, got);
        end
    endtask
    // one-cycle strobes, results settled by the following falling edge
    task automatic pulse(input logic ev, input logic ad, input logic cl);
        @(negedge clock_i);
        ev_valid_i = ev;
        addr_valid_i = ad;
        clear_i = cl;
        @(negedge clock_i);
        ev_valid_i = 1'b0;
        addr_valid_i = 1'b0;
        clear_i = 1'b0;
        @(negedge clock_i);
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clock_i);
        reset_i = 1'b0;
        @(negedge clock_i);
        @(negedge clock_i);
        chk("bank", {56'h0, bank_o}, 64'h0c);
        chk("status", status_o, 64'h0);
        // each flag alone, logged with clear, over a live entry from the second flag on
        for (int k = 0; k < 7; k++)
        begin
            ev_i = '0;
            ev_i[20 - k] = 1'b1;
            ev_i.txn_type = 3'(k);
            ev_i.channel = 4'(k + 8);
            ev_i.memory_type_error_field = 2'(k);
            ev_i.misc_error_field = 6'h2a;
            ev_i.other_info = 6'(k + 33);
            pulse(1'b1, 1'b0, 1'b1);
            exp = {1'b1, 25'h0, 6'(k + 33), 6'h2a, 2'(k), 16'h0, 1'b1,
                3'(k), 4'(k + 8)};
            exp[k == 0 ? 16 : 17 + k] = 1'b1;
            chk("status", status_o, exp);
            chk("flags", status_o, exp);
            chk("valid", {63'h0, valid_o}, 64'h1);
        end
        ev_i = '1;
        pulse(1'b1, 1'b0, 1'b0);
        chk("status held", status_o, exp);
        pulse(1'b0, 1'b0, 1'b1);
        chk("status cleared", status_o, 64'h0);
        chk("valid cleared", {63'h0, valid_o}, 64'h0);
        for (int m = 0; m < 5; m++)
        begin
            addr_i = '{10'h3ff, 21'(m * 12345 + 1), 6'h3f, 6'h2a, 4'(m),
                3'(m + 2), modes[m], m[0], m < 3};
            misc_low_i = 9'(m * 100);
            pulse(1'b0, 1'b1, 1'b1);
            exp = {m[0], modes[m], 3'(m + 2), 4'(m),
                (m < 3 && !m[0]) ? 6'h2a : 6'h00, 1'b0, 5'h1f,
                21'(m * 12345 + 1), 2'b00, 7'h7f, 1'b0, 9'(m * 100)};
            chk("detail", detail_o, exp);
        end
        addr_i = '0;
        pulse(1'b0, 1'b1, 1'b0);
        chk("detail held", detail_o, exp);
        // mid-run reset: everything back to zero, bank reloads one edge later
        @(negedge clock_i);
        reset_i = 1'b1;
        @(negedge clock_i);
        reset_i = 1'b0;
        chk("reset status", status_o, 64'h0);
        chk("reset valid", {63'h0, valid_o}, 64'h0);
        chk("reset detail", detail_o, 64'h0);
        chk("reset bank", {56'h0, bank_o}, 64'h0);
        @(negedge clock_i);
        chk("bank again", {56'h0, bank_o}, 64'h0c);
        complete_run;
    end
endmodule
